// >>> pkg/pin_sync_if.sv
`timescale 1ns/10ps
interface pin_sync_if;
  logic key_low;
  logic hard_low;
  logic fast_fall;
  modport src (output key_low, output hard_low, output fast_fall);
  modport dst (input key_low, input hard_low, input fast_fall);
endinterface

// >>> pkg/power_seq_pkg.sv
package power_seq_pkg;
  // Times as printed, counts derived at 100 MHz
  localparam int unsigned CLK_HZ           = 100_000_000;
  localparam int unsigned PWR_ON_HOLD_S    = 5;
  localparam int unsigned PWR_OFF_HOLD_S   = 3;
  localparam int unsigned WAKE_HOLD_S      = 5;
  localparam int unsigned HARD_SHDN_MS     = 200;
  localparam int unsigned ORDERLY_OFF_MS   = 1000;
  localparam int unsigned PWR_ON_HOLD_CYC  = PWR_ON_HOLD_S * CLK_HZ;
  localparam int unsigned PWR_OFF_HOLD_CYC = PWR_OFF_HOLD_S * CLK_HZ;
  localparam int unsigned WAKE_HOLD_CYC    = WAKE_HOLD_S * CLK_HZ;
  localparam int unsigned HARD_SHDN_CYC    = HARD_SHDN_MS * (CLK_HZ / 1000);
  localparam int unsigned ORDERLY_OFF_CYC  = ORDERLY_OFF_MS * (CLK_HZ / 1000);
  localparam int unsigned POR_CYC          = 16;
  localparam int unsigned CNT_W            = 32;

  typedef enum logic [2:0] {
    ST_POR,
    ST_OFF,
    ST_ON,
    ST_DETACH,
    ST_CLOSING,
    ST_SLEEP,
    ST_HARD_RST
  } pwr_state_t;
endpackage

// >>> tb/host_pin_model.sv
`timescale 1ns/10ps
module host_pin_model (
  // Requests from the bench
  input  wire logic key_pull,
  input  wire logic hard_pull,
  // Device side of the key pin
  input  wire logic key_o,
  input  wire logic key_oe,
  // Wire levels
  output logic      key_n,
  output logic      hard_n
);
  assign key_n  = (key_pull || (key_oe && !key_o)) ? 1'b0 : 1'b1;
  // pulled low only, never driven high
  assign hard_n = hard_pull ? 1'b0 : 1'b1;
endmodule

// >>> tb/test_module_power_control_sequencer.sv
`timescale 1ns/10ps
module test_module_power_control_sequencer;
  localparam int ON_C = 40, OFF_C = 30, WK_C = 40, HD_C = 20, ORD_C = 25;
  logic ref_clk, rst_n, key_pull, hard_pull, fast_gpio, fast_en, sd_cmd, upd, det_done;
  logic key_o, key_oe, key_n, hard_n, mon, aux, det_req, core_n, sleep, det_seen, ce;
  int   fail_count, cmp_count, cyc, h, n;

  host_pin_model u_host_pin_model (.key_pull(key_pull), .hard_pull(hard_pull),
    .key_o(key_o), .key_oe(key_oe), .key_n(key_n), .hard_n(hard_n));
  module_power_control_sequencer #(.PWR_ON_CYC(ON_C), .PWR_OFF_CYC(OFF_C),
    .WAKE_CYC(WK_C), .HARD_CYC(HD_C), .ORDERLY_CYC(ORD_C)) u_module_power_control_sequencer (
    .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(ce), .power_key_n_i(key_n),
    .power_key_n_o(key_o), .power_key_n_oe(key_oe), .hard_shutdown_n(hard_n),
    .fast_gpio(fast_gpio), .fast_down_enable(fast_en), .shutdown_cmd(sd_cmd),
    .update_timer_expired(upd), .detach_done(det_done), .power_monitor_out(mon),
    .aux_supply_out(aux), .detach_request(det_req), .core_reset_n(core_n),
    .deep_sleep_power_saving(sleep));

  initial ref_clk = 1'b0;
  always #5 ref_clk = ~ref_clk;

  // Sticky record of any detach, cleared by the bench before the hard and fast scenarios
  always @(posedge ref_clk) begin
    if (det_req === 1'b1) det_seen = 1'b1;
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      final_report();
    end
  end

  function automatic logic exp_on(input int held);
    return held >= ON_C;
  endfunction

  task automatic tick(input int k);
    repeat (k) @(negedge ref_clk);
  endtask

  task automatic check_bit(input string what, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic wait_mon(input logic v, input int lim);
    int i;
    i = 0;
    while (mon !== v && i < lim) begin
      tick(1);
      i++;
    end
  endtask

  // Holds the key, then releases it and lets the monitor settle
  task automatic press(input int k);
    key_pull = 1'b1;
    tick(k);
    key_pull = 1'b0;
    wait_mon(1'b1, 20);
  endtask

  task automatic pulse_done();
    det_done = 1'b1;
    tick(1);
    det_done = 1'b0;
  endtask

  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    {rst_n, key_pull, hard_pull, fast_en, sd_cmd, upd, det_done, det_seen} = '0;
    fast_gpio = 1'b1;
    ce = 1'b1;
    fail_count = 0;
    cmp_count = 0;
    cyc = 0;
    void'($urandom(69454));
    tick(16);
    rst_n = 1'b1;
    tick(25);
    check_bit("core reset after por", 1'b1, core_n);
    check_bit("key pin never driven", 1'b0, key_oe);
    check_bit("key pin level high", 1'b1, key_o);
    // too short a hold is refused
    h = ON_C - 2 - $urandom_range(0, 10);
    press(h);
    check_bit("monitor short press", exp_on(h), mon);
    h = ON_C + $urandom_range(0, 10);
    press(h);
    check_bit("monitor on", exp_on(h), mon);
    check_bit("aux on", 1'b1, aux);
    key_pull = 1'b1;
    n = 0;
    while (det_req !== 1'b1 && n < OFF_C + 10) begin
      tick(1);
      n++;
    end
    check_bit("detach on key hold", 1'b1, det_req);
    check_bit("monitor during detach", 1'b1, mon);
    key_pull = 1'b0;
    tick(3 + $urandom_range(0, 5));
    pulse_done();
    n = 0;
    while (mon === 1'b1 && n < ORD_C + 20) begin
      tick(1);
      n++;
    end
    check_bit("orderly length", 1'b1, n >= ORD_C - 1);
    check_bit("monitor off", 1'b0, mon);
    check_bit("detach cleared", 1'b0, det_req);
    // each sequence waits for the monitor change
    press(ON_C + 2);
    sd_cmd = 1'b1;
    tick(1);
    sd_cmd = 1'b0;
    tick(4);
    check_bit("detach on command", 1'b1, det_req);
    pulse_done();
    wait_mon(1'b0, ORD_C + 20);
    check_bit("monitor off cmd", 1'b0, mon);
    press(ON_C + 2);
    upd = 1'b1;
    tick(1);
    upd = 1'b0;
    wait_mon(1'b0, 10);
    check_bit("sleep entered", 1'b1, sleep);
    check_bit("monitor in sleep", 1'b0, mon);
    hard_pull = 1'b1;
    tick(HD_C + 5);
    hard_pull = 1'b0;
    tick(5);
    check_bit("sleep kept", 1'b1, sleep);
    check_bit("no reset in sleep", 1'b1, core_n);
    press(WK_C + 3);
    check_bit("monitor woken", 1'b1, mon);
    check_bit("sleep left", 1'b0, sleep);
    // hard hold while monitor is high
    det_seen = 1'b0;
    h = HD_C + $urandom_range(0, 20);
    hard_pull = 1'b1;
    tick(5);
    check_bit("core held in reset", 1'b0, core_n);
    check_bit("monitor in reset", 1'b0, mon);
    tick(h);
    hard_pull = 1'b0;
    tick(10);
    check_bit("off after hard", 1'b0, mon);
    check_bit("core released", 1'b1, core_n);
    check_bit("no detach hard", 1'b0, det_seen);
    press(ON_C + 1);
    // Frozen clock enable must swallow a timer expiry
    ce = 1'b0;
    upd = 1'b1;
    tick(4);
    upd = 1'b0;
    ce = 1'b1;
    tick(2);
    check_bit("sleep while frozen", 1'b0, sleep);
    check_bit("monitor while frozen", 1'b1, mon);
    det_seen = 1'b0;
    fast_gpio = 1'b0;
    tick(10);
    check_bit("fast edge disabled", 1'b1, mon);
    fast_gpio = 1'b1;
    tick(5);
    fast_en = 1'b1;
    fast_gpio = 1'b0;
    wait_mon(1'b0, 10);
    check_bit("fast off", 1'b0, mon);
    check_bit("no detach fast", 1'b0, det_seen);
    final_report();
  end
endmodule

// >>> verilog/module_power_control_sequencer.sv
`timescale 1ns/10ps
// Overview of operation
// [RULE1] Host holds key low five seconds
// [RULE2] Monitor stays high whole powered-on time
// [RULE3] Host drives key open-drain, no pull-up; host_pin_model supplies the pull-up
// [RULE4] Key low three seconds starts orderly off
// [RULE5] Orderly off sends detach request first
// [RULE6] Monitor low means off or sleep
// [RULE7] Orderly off takes over one second
// [RULE8] Update timer expiry enters deep sleep
// [RULE9] Key low five seconds wakes sleep
// [RULE10] Host polls monitor for deep sleep
// [RULE11] Hard shutdown low holds reset, stops; ignored in ST_CLOSING
// [RULE12] Hard shutdown release: off, no detach
// [RULE13] Host holds hard shutdown 200 ms
// [RULE14] Hard shutdown sequenced internally at start-up
// [RULE15] Host uses open collector on shutdown
// [RULE16] Deep sleep ignores hard shutdown toggling
// [RULE17] Host uses shutdown only monitor high
// [RULE18] Host powers on above battery threshold
// [RULE19] Configured GPIO falling edge: fast shutdown
// [RULE20] Host waits monitor change between sequences
module module_power_control_sequencer
  import power_seq_pkg::*;
#(
  parameter int unsigned PWR_ON_CYC   = PWR_ON_HOLD_CYC,
  parameter int unsigned PWR_OFF_CYC  = PWR_OFF_HOLD_CYC,
  parameter int unsigned WAKE_CYC     = WAKE_HOLD_CYC,
  parameter int unsigned HARD_CYC     = HARD_SHDN_CYC,
  parameter int unsigned ORDERLY_CYC  = ORDERLY_OFF_CYC
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic clk_en,
  // Host pins, open drain, pull-up in the external host model
  input  wire logic power_key_n_i,
  output logic      power_key_n_o,
  output logic      power_key_n_oe,
  input  wire logic hard_shutdown_n,
  // Fast power-down GPIO and its configuration
  input  wire logic fast_gpio,
  input  wire logic fast_down_enable,
  // Internal firmware events
  input  wire logic shutdown_cmd,
  input  wire logic update_timer_expired,
  input  wire logic detach_done,
  // Status and control outputs
  output logic      power_monitor_out,
  output logic      aux_supply_out,
  output logic      detach_request,
  output logic      core_reset_n,
  output logic      deep_sleep_power_saving
);
  pin_sync_if pins ();

  pin_sync u_sync (
    .ref_clk         (ref_clk),
    .rst_n           (rst_n),
    .clk_en          (clk_en),
    .power_key_n_i   (power_key_n_i),
    .hard_shutdown_n (hard_shutdown_n),
    .fast_gpio       (fast_gpio),
    .sync            (pins.src)
  );

  typedef struct packed {
    pwr_state_t       st;
    logic [CNT_W-1:0] key_cnt;
    logic [CNT_W-1:0] hard_cnt;
    logic [CNT_W-1:0] tmr;
    logic             key_armed;
    logic             detach_req;
    logic             mon;
  } seq_t;

  seq_t s_r;
  seq_t s_nxt;

  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
    sat_inc = (&v) ? v : v + 1'b1;
  endfunction

  function automatic logic reached(input logic [CNT_W-1:0] v, input int unsigned lim);
    reached = v >= CNT_W'(lim);
  endfunction

  // Pin is only ever an input to the host's open drain; pull-up is external model
  assign power_key_n_o  = 1'b1;
  assign power_key_n_oe = 1'b0;

  always_comb begin
    s_nxt = s_r;
    if (clk_en) begin
      s_nxt.key_cnt  = pins.key_low ? sat_inc(s_r.key_cnt) : '0;
      s_nxt.hard_cnt = pins.hard_low ? sat_inc(s_r.hard_cnt) : '0;
      if (!pins.key_low) begin
        s_nxt.key_armed = 1'b1;
      end
      case (s_r.st)
        // [RULE14] Internal power-on reset
        ST_POR: begin
          s_nxt.tmr = sat_inc(s_r.tmr);
          if (reached(s_r.tmr, POR_CYC - 1)) begin
            s_nxt.st  = ST_OFF;
            s_nxt.tmr = '0;
          end
        end
        ST_OFF: begin
          // [RULE1] Power-on hold then release
          if (!pins.key_low && reached(s_r.key_cnt, PWR_ON_CYC) && s_r.key_armed) begin
            s_nxt.st        = ST_ON;
            s_nxt.mon       = 1'b1;
            s_nxt.key_armed = 1'b0;
          end
        end
        ST_ON: begin
          // [RULE11] Hard shutdown holds reset
          if (pins.hard_low) begin
            s_nxt.st  = ST_HARD_RST;
            s_nxt.mon = 1'b0;
          // [RULE19] Fast shutdown skips detach
          end else if (fast_down_enable && pins.fast_fall) begin
            s_nxt.st  = ST_OFF;
            s_nxt.mon = 1'b0;
          // [RULE4] Key hold starts orderly off
          end else if ((s_r.key_armed && pins.key_low &&
                        reached(s_r.key_cnt, PWR_OFF_CYC - 1)) || shutdown_cmd) begin
            s_nxt.st         = ST_DETACH;
            s_nxt.detach_req = 1'b1;
            s_nxt.key_armed  = 1'b0;
            s_nxt.tmr        = '0;
          // [RULE8] Timer expiry enters sleep
          end else if (update_timer_expired) begin
            s_nxt.st  = ST_SLEEP;
            s_nxt.mon = 1'b0;
          end
        end
        // [RULE5] Detach before going down
        ST_DETACH: begin
          s_nxt.tmr = sat_inc(s_r.tmr);
          if (pins.hard_low) begin
            s_nxt.st         = ST_HARD_RST;
            s_nxt.detach_req = 1'b0;
            s_nxt.mon        = 1'b0;
          end else if (detach_done) begin
            // Closing time counts from the detach, not from the request
            s_nxt.st         = ST_CLOSING;
            s_nxt.detach_req = 1'b0;
            s_nxt.tmr        = '0;
          end
        end
        // [RULE7] Filesystem close, at least one second
        ST_CLOSING: begin
          s_nxt.tmr = sat_inc(s_r.tmr);
          if (reached(s_r.tmr, ORDERLY_CYC - 1)) begin
            s_nxt.st  = ST_OFF;
            s_nxt.mon = 1'b0;
            s_nxt.tmr = '0;
          end
        end
        ST_SLEEP: begin
          // [RULE16] Hard shutdown ignored here
          // [RULE9] Five-second key wakes
          if (!pins.key_low && reached(s_r.key_cnt, WAKE_CYC) && s_r.key_armed) begin
            s_nxt.st        = ST_ON;
            s_nxt.mon       = 1'b1;
            s_nxt.key_armed = 1'b0;
          end
        end
        ST_HARD_RST: begin
          // [RULE12] Release ends off, no detach
          if (!pins.hard_low) begin
            s_nxt.st = ST_OFF;
          end
        end
        default: s_nxt.st = ST_OFF;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '{st: ST_POR, key_cnt: '0, hard_cnt: '0, tmr: '0,
               key_armed: 1'b0, detach_req: 1'b0, mon: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // [RULE2] Monitor is the powered-on state, no override
  // [RULE6] Low once off or asleep
  assign power_monitor_out       = s_r.mon;
  assign aux_supply_out          = s_r.mon;
  assign detach_request          = s_r.detach_req;
  assign core_reset_n            = (s_r.st != ST_HARD_RST) && (s_r.st != ST_POR);
  assign deep_sleep_power_saving = (s_r.st == ST_SLEEP);

  sequence on_and_no_hard;
    (s_r.st == ST_ON) && clk_en && !pins.hard_low;
  endsequence

  chk_mon_follows_state: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE2]
    power_monitor_out == (s_r.st inside {ST_ON, ST_DETACH, ST_CLOSING}))
    else $error("monitor does not match powered state");

  chk_off_drops_mon: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE6]
    (s_r.st == ST_CLOSING) && (s_nxt.st == ST_OFF) |=> !power_monitor_out)
    else $error("monitor stayed high after power off");

  chk_detach_on_cmd: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE5]
    on_and_no_hard ##0 (shutdown_cmd && !(fast_down_enable && pins.fast_fall))
      |=> detach_request && (s_r.st == ST_DETACH))
    else $error("orderly off without detach request");

  chk_close_min_time: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE7]
    (s_r.st == ST_DETACH) ##1 (s_r.st == ST_CLOSING) |-> s_r.tmr == '0)
    else $error("closing phase started with timer not cleared");

  chk_hard_holds_rst: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE11]
    on_and_no_hard ##1 (pins.hard_low && clk_en && (s_r.st == ST_ON))
      |=> !core_reset_n && !power_monitor_out)
    else $error("hard shutdown did not hold reset");

  chk_hard_no_detach: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE12]
    (s_r.st == ST_HARD_RST) |-> !detach_request)
    else $error("detach requested during hard shutdown");

  chk_sleep_ignores_hard: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE16]
    (s_r.st == ST_SLEEP) && pins.hard_low |=> (s_r.st inside {ST_SLEEP, ST_ON}) && core_reset_n)
    else $error("deep sleep left on hard shutdown");

  chk_timer_sleep: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE8]
    on_and_no_hard ##0 (update_timer_expired && !shutdown_cmd && !pins.key_low &&
      !(fast_down_enable && pins.fast_fall)) |=> deep_sleep_power_saving)
    else $error("timer expiry did not enter deep sleep");

  chk_fast_down: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE19]
    on_and_no_hard ##0 (fast_down_enable && pins.fast_fall)
      |=> !power_monitor_out && !detach_request)
    else $error("fast power down not taken");

  chk_por_release: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE14]
    (s_r.st == ST_POR) |-> !core_reset_n && !power_monitor_out)
    else $error("core out of reset during start-up");
endmodule

// >>> verilog/pin_sync.sv
`timescale 1ns/10ps
module pin_sync
  import power_seq_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic clk_en,
  input  wire logic power_key_n_i,
  input  wire logic hard_shutdown_n,
  input  wire logic fast_gpio,
  pin_sync_if.src   sync
);
  typedef struct packed {
    logic [1:0] key;
    logic [1:0] hard;
    logic [2:0] gpio;
  } sync_t;

  sync_t s_r;
  sync_t s_nxt;

  // Pulled-up pins idle high, so reset to high
  always_comb begin
    s_nxt = s_r;
    if (clk_en) begin
      s_nxt.key  = {s_r.key[0], power_key_n_i};
      s_nxt.hard = {s_r.hard[0], hard_shutdown_n};
      s_nxt.gpio = {s_r.gpio[1:0], fast_gpio};
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '{key: 2'h3, hard: 2'h3, gpio: 3'h7};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign sync.key_low   = !s_r.key[1];
  assign sync.hard_low  = !s_r.hard[1];
  // Edge uses stages 2 and 3 only, never the first flop
  assign sync.fast_fall = s_r.gpio[2] && !s_r.gpio[1];
endmodule
